/* File: design/rts_timer_section.sv */
// What this block does
// - Run-control write changes a run bit only where its mask bit is one.
// - Mask nibble all ones loads all run bits; all zeros changes none.
// - Run bits show timers three..zero counting; masked write starts or stops them.
// - Low nibble bits are write-only masks, each for the run bit four above.
// - Stop-on-receive set: timer zero stops after first four received bits.
// - Stop-on-receive is ignored in either oscillator trimming mode.
// - Start mode 00 no auto start; 01 starts at end of transmission.
// - Modes 10/11 trimming without/with underflow, start and stop on rising edges.
// - Auto-restart set, except in mode 10: at zero reload from sixteen-bit value and keep counting.
// - Auto-restart clear, except in mode 11: count to zero then stop and clear running.
// - Every underflow sets the timer's interrupt request flag.
// - Clock select 00 is carrier rate, 01 is carrier divided down.
// - Clock select 10 ticks on timer two, 11 on timer one underflow.
// - Reload value is high and low byte registers, both read and write.
// - Every start event loads the counter with the reload value.
// - Reload writes leave a running count alone until next start.
`timescale 1ns/100ps
`default_nettype none
module rts_timer_section import rts_pkg::*; (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Register bus
   input wire rts_wb_req_t wbReq,
   output rts_wb_rsp_t wbRsp,
   // Frame events from the transceiver, same clock
   input wire logic txFrameDone,
   input wire logic rxFourBitsSeen,
   // Pins from other clock sources
   input wire logic carrierPin,
   input wire logic lfoPin,
   // Sibling timers
   input wire logic timerOneUnderflow,
   input wire logic timerTwoUnderflow,
   output logic [3:1] siblingRun,
   output logic timerZeroUnderflow,
   output logic [15:0] counterValue,
   // Interrupt
   output logic irq
);

   rts_state_t q;
   rts_state_t d;
   logic carRise;
   logic lfoRise;
   logic slowTick;
   logic tick;
   logic lfoMode;
   logic busReq;
   logic busWr;
   logic runWr;
   logic relWr;
   logic [5:0] idx;
   logic [15:0] reloadVal;
   logic startZero;
   logic stopZero;
   logic [1:0] statSet;
   logic [1:0] statClr;

   assign idx = wbReq.adr[7:2];
   assign busReq = wbReq.cyc & wbReq.stb & ~q.ack;
   assign busWr = busReq & wbReq.we & wbReq.sel[0];
   assign runWr = busWr && idx == IDX_RUN_CONTROL;
   assign relWr = busWr && (idx == IDX_RELOAD_HIGH || idx == IDX_RELOAD_LOW);
   assign reloadVal = {q.reloadHi, q.reloadLo};

   // A change counts only once the second and third stages agree
   assign carRise = q.carSync[1] & q.carSync[2] & ~q.carLvl;
   assign lfoRise = q.lfoSync[1] & q.lfoSync[2] & ~q.lfoLvl;
   // Carrier is slightly above half of mclk, so edges can merge; expect a large undercount
   assign slowTick = carRise && q.divCnt == SLOW_LAST;
   assign lfoMode = q.startMode[1];

   always_comb begin
      unique case (q.clkSel)
         CLK_CARRIER: tick = carRise;
         CLK_SLOW: tick = slowTick;
         CLK_TIMER_TWO: tick = timerTwoUnderflow;
         CLK_TIMER_ONE: tick = timerOneUnderflow;
      endcase
   end

   always_comb begin
      d = q;
      d.ack = busReq;
      d.uflow = 1'b0;
      startZero = 1'b0;
      stopZero = 1'b0;
      statSet = 2'b00;
      statClr = 2'b00;
      d.carSync = {q.carSync[1:0], carrierPin};
      d.lfoSync = {q.lfoSync[1:0], lfoPin};
      if (q.carSync[1] == q.carSync[2]) begin
         d.carLvl = q.carSync[2];
      end
      if (q.lfoSync[1] == q.lfoSync[2]) begin
         d.lfoLvl = q.lfoSync[2];
      end
      if (carRise) begin
         d.divCnt = (q.divCnt == SLOW_LAST) ? 6'h0 : q.divCnt + 6'h1;
      end

      // Counting
      if (q.run[0] && tick) begin
         if (q.count == 16'h0000) begin
            if (q.startMode == START_LFO_HOLD) begin
               stopZero = 1'b1;
            end else begin
               d.uflow = 1'b1;
               statSet[IRQ_UNDERFLOW_BIT] = 1'b1;
               if (q.autoReload || q.startMode == START_LFO_WRAP) begin
                  d.count = reloadVal;
               end else begin
                  stopZero = 1'b1;
               end
            end
         end else begin
            d.count = q.count - 16'h0001;
         end
      end

      // Hardware start and stop events
      if (q.startMode == START_TX_END && txFrameDone) begin
         startZero = 1'b1;
      end
      if (lfoMode && lfoRise) begin
         if (q.run[0]) begin
            stopZero = 1'b1;
         end else begin
            startZero = 1'b1;
         end
      end
      if (q.haltRx && !lfoMode && rxFourBitsSeen && q.run[0]) begin
         stopZero = 1'b1;
         statSet[IRQ_HALT_RX_BIT] = 1'b1;
      end
      if (stopZero) begin
         d.run[0] = 1'b0;
      end
      if (startZero) begin
         d.run[0] = 1'b1;
         d.count = reloadVal;
      end

      // Software writes win over same-cycle hardware events, except on the interrupt status flags
      if (busWr) begin
         unique case (idx)
            IDX_RUN_CONTROL: begin
               for (int i = 0; i < 4; i++) begin
                  if (wbReq.dat[i]) begin
                     d.run[i] = wbReq.dat[i + RUN_LO];
                  end
               end
               if (wbReq.dat[0] && wbReq.dat[RUN_LO]) begin
                  d.count = reloadVal;
               end
            end
            IDX_ZERO_CONTROL: begin
               d.haltRx = wbReq.dat[CTL_HALT_BIT];
               d.startMode = rts_start_t'(wbReq.dat[CTL_MODE_LO +: 2]);
               d.autoReload = wbReq.dat[CTL_RELOAD_BIT];
               d.clkSel = rts_clksel_t'(wbReq.dat[CTL_CLK_LO +: 2]);
            end
            IDX_RELOAD_HIGH: d.reloadHi = wbReq.dat[7:0];
            IDX_RELOAD_LOW: d.reloadLo = wbReq.dat[7:0];
            IDX_IRQ_STATUS: statClr = wbReq.dat[1:0];
            IDX_IRQ_MASK: d.mask = wbReq.dat[1:0];
            default: ;
         endcase
      end
      // Set wins over a write-one clear in the same cycle
      d.status = (q.status & ~statClr) | statSet;

      // Reads; mask nibble is write-only and reads as zero
      if (busReq && !wbReq.we) begin
         d.rdData = 32'h0000_0000;
         unique case (idx)
            IDX_RUN_CONTROL: d.rdData[7:0] = {q.run, 4'h0};
            IDX_ZERO_CONTROL: d.rdData[7:0] = {q.haltRx, 1'b0, q.startMode, q.autoReload, 1'b0, q.clkSel};
            IDX_RELOAD_HIGH: d.rdData[7:0] = q.reloadHi;
            IDX_RELOAD_LOW: d.rdData[7:0] = q.reloadLo;
            IDX_IRQ_STATUS: d.rdData[1:0] = q.status;
            IDX_IRQ_MASK: d.rdData[1:0] = q.mask;
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         q <= RTS_STATE_RESET;
      end else begin
         q <= d;
      end
   end

   assign wbRsp = '{ack: q.ack, dat: q.rdData};
   assign siblingRun = q.run[3:1];
   assign timerZeroUnderflow = q.uflow;
   assign counterValue = q.count;
   assign irq = |(q.status & q.mask);

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   AST_MASK_NONE: assert property (runWr && wbReq.dat[3:0] == 4'h0 |=> q.run[3:1] == $past(q.run[3:1]))
      else $error("Run bits changed under a zero mask");
   AST_MASK_LOAD: assert property (runWr && wbReq.dat[3] |=> q.run[3] == $past(wbReq.dat[7]))
      else $error("Masked run bit not loaded");
   AST_SW_START: assert property (runWr && wbReq.dat[0] && wbReq.dat[4] |=> q.run[0] && q.count == $past(reloadVal))
      else $error("Software start did not load reload value");
   AST_RELOAD_ISOLATED: assert property (relWr && q.run[0] && !tick && !startZero |=> $stable(q.count))
      else $error("Reload write disturbed running count");
   AST_DECREMENT: assert property (q.run[0] && tick && q.count != 16'h0000 && !startZero && !runWr
      |=> q.count == $past(q.count) - 16'h0001)
      else $error("Counter did not decrement on tick");
   AST_STOPPED_HOLD: assert property (!q.run[0] && !startZero && !runWr |=> $stable(q.count))
      else $error("Stopped counter changed");
   AST_RESTART: assert property (q.run[0] && tick && q.count == 16'h0000 && q.autoReload && !lfoMode
      && !startZero && !stopZero && !runWr |=> q.run[0] && q.count == $past(reloadVal) && q.uflow)
      else $error("Auto restart did not reload");
   AST_ONE_SHOT: assert property (q.run[0] && tick && q.count == 16'h0000 && !q.autoReload && !lfoMode
      && !startZero && !runWr |=> !q.run[0] && q.uflow)
      else $error("One-shot timer did not stop at zero");
   AST_UFLOW_FLAG: assert property (q.uflow |-> q.status[IRQ_UNDERFLOW_BIT])
      else $error("Underflow did not set interrupt flag");
   AST_HALT_RX: assert property (q.haltRx && !lfoMode && rxFourBitsSeen && !startZero && !runWr |=> !q.run[0])
      else $error("Timer not halted on receive");
   AST_HALT_IGNORED: assert property (lfoMode && rxFourBitsSeen && q.run[0] && !tick && !lfoRise && !runWr
      |=> q.run[0])
      else $error("Stop on receive acted in trimming mode");
   AST_AUTO_START: assert property (q.startMode == START_TX_END && txFrameDone && !runWr
      |=> q.run[0] && q.count == $past(reloadVal))
      else $error("No automatic start after transmission");
   AST_LFO_START: assert property (lfoMode && lfoRise && !q.run[0] && !runWr |=> q.run[0])
      else $error("Trimming edge did not start timer");
   AST_RESERVED_ZERO: assert property (busReq && !wbReq.we && idx == IDX_ZERO_CONTROL
      |=> q.ack && q.rdData[6] == 1'b0 && q.rdData[2] == 1'b0)
      else $error("Reserved control bits read non-zero");

   // Bus handshake: one ack per taken request, data in the low byte only
   AST_ACK_AFTER_REQ: assert property (busReq
      |=> q.ack)
      else $error("Taken request not acknowledged");
   AST_ACK_PULSE: assert property (q.ack
      |=> !q.ack)
      else $error("Acknowledge held for two cycles");
   AST_NO_SPURIOUS_ACK: assert property (!busReq
      |=> !q.ack)
      else $error("Acknowledge without request");
   AST_UPPER_READ_ZERO: assert property (busReq && !wbReq.we
      |=> q.rdData[31:8] == 24'h00_0000)
      else $error("Upper read data not zero");
   AST_RUN_READ: assert property (busReq && !wbReq.we && idx == IDX_RUN_CONTROL
      |=> q.rdData[7:0] == {$past(q.run), 4'h0})
      else $error("Run control read wrong");
   AST_RELOAD_HI_READ: assert property (busReq && !wbReq.we && idx == IDX_RELOAD_HIGH
      |=> q.rdData[7:0] == $past(q.reloadHi))
      else $error("Reload high byte read wrong");
   AST_RELOAD_LO_READ: assert property (busReq && !wbReq.we && idx == IDX_RELOAD_LOW
      |=> q.rdData[7:0] == $past(q.reloadLo))
      else $error("Reload low byte read wrong");
   AST_STATUS_READ: assert property (busReq && !wbReq.we && idx == IDX_IRQ_STATUS
      |=> q.rdData[1:0] == $past(q.status))
      else $error("Status read wrong");
   AST_MASK_READ: assert property (busReq && !wbReq.we && idx == IDX_IRQ_MASK
      |=> q.rdData[1:0] == $past(q.mask))
      else $error("Mask read wrong");
   AST_SEL_IGNORED: assert property (busReq && wbReq.we && !wbReq.sel[0]
      |=> $stable(q.reloadHi) && $stable(q.mask))
      else $error("Write without byte select took effect");

   // Register writes
   AST_RELOAD_HI_WRITE: assert property (busWr && idx == IDX_RELOAD_HIGH
      |=> q.reloadHi == $past(wbReq.dat[7:0]))
      else $error("Reload high byte not written");
   AST_RELOAD_LO_WRITE: assert property (busWr && idx == IDX_RELOAD_LOW
      |=> q.reloadLo == $past(wbReq.dat[7:0]))
      else $error("Reload low byte not written");
   AST_CTL_FLAGS_WRITE: assert property (busWr && idx == IDX_ZERO_CONTROL
      |=> q.haltRx == $past(wbReq.dat[CTL_HALT_BIT]) && q.autoReload == $past(wbReq.dat[CTL_RELOAD_BIT]))
      else $error("Control flags not written");
   AST_CTL_FIELDS_WRITE: assert property (busWr && idx == IDX_ZERO_CONTROL
      |=> q.startMode == $past(wbReq.dat[CTL_MODE_LO +: 2]) && q.clkSel == $past(wbReq.dat[CTL_CLK_LO +: 2]))
      else $error("Control fields not written");
   AST_MASK_WRITE: assert property (busWr && idx == IDX_IRQ_MASK
      |=> q.mask == $past(wbReq.dat[1:0]))
      else $error("Interrupt mask not written");
   AST_RELOAD_HOLD: assert property (!(busWr && idx == IDX_RELOAD_HIGH)
      |=> $stable(q.reloadHi))
      else $error("Reload high byte changed without write");

   // Run control
   AST_FULL_MASK: assert property (runWr && wbReq.dat[3:0] == 4'hf
      |=> q.run == $past(wbReq.dat[7:4]))
      else $error("Full mask did not load all run bits");
   AST_MASK_ONE_HOLD: assert property (runWr && !wbReq.dat[1]
      |=> q.run[1] == $past(q.run[1]))
      else $error("Unmasked run bit one changed");
   AST_MASK_TWO_HOLD: assert property (runWr && !wbReq.dat[2]
      |=> q.run[2] == $past(q.run[2]))
      else $error("Unmasked run bit two changed");
   AST_MASK_THREE_HOLD: assert property (runWr && !wbReq.dat[3]
      |=> q.run[3] == $past(q.run[3]))
      else $error("Unmasked run bit three changed");
   AST_SW_STOP: assert property (runWr && wbReq.dat[0] && !wbReq.dat[4]
      |=> !q.run[0])
      else $error("Software stop ignored");
   AST_SIBLING_HOLD: assert property (!runWr
      |=> q.run[3:1] == $past(q.run[3:1]))
      else $error("Sibling run bits changed without write");
   AST_SW_RESTART: assert property (runWr && wbReq.dat[0] && wbReq.dat[4] && q.run[0]
      |=> q.count == $past(reloadVal))
      else $error("Restart while running did not reload");

   // Hardware start and stop
   AST_NO_AUTO_START: assert property (q.startMode == START_NONE && !q.run[0] && !runWr
      |=> !q.run[0])
      else $error("Timer started without a start event");
   AST_LFO_STOP: assert property (lfoMode && lfoRise && q.run[0] && !runWr
      |=> !q.run[0])
      else $error("Trimming edge did not stop timer");
   AST_HOLD_NO_UFLOW: assert property (q.startMode == START_LFO_HOLD && q.run[0] && tick && q.count == 16'h0000
      && !lfoRise && !runWr |=> !q.run[0] && !q.uflow)
      else $error("Trimming without underflow misbehaved at zero");
   AST_WRAP_RELOAD: assert property (q.startMode == START_LFO_WRAP && q.run[0] && tick && q.count == 16'h0000
      && !lfoRise && !runWr |=> q.run[0] && q.uflow && q.count == $past(reloadVal))
      else $error("Trimming with underflow did not wrap");
   AST_HALT_OFF: assert property (!q.haltRx && !lfoMode && q.run[0] && !(tick && q.count == 16'h0000)
      && !runWr |=> q.run[0])
      else $error("Timer stopped without a stop event");
   AST_HALT_FLAG: assert property (q.haltRx && !lfoMode && rxFourBitsSeen && q.run[0]
      |=> q.status[IRQ_HALT_RX_BIT])
      else $error("Receive halt did not set its flag");
   AST_LFO_NO_TX: assert property (lfoMode && txFrameDone && !q.run[0] && !lfoRise && !runWr
      |=> !q.run[0])
      else $error("End of transmission started a trimming timer");

   // Counting and clock selection
   AST_UFLOW_SETS: assert property (q.run[0] && tick && q.count == 16'h0000 && q.startMode != START_LFO_HOLD
      |=> q.uflow && q.status[IRQ_UNDERFLOW_BIT])
      else $error("Underflow not flagged");
   AST_UFLOW_ONLY_AT_ZERO: assert property (!(q.run[0] && tick && q.count == 16'h0000)
      |=> !q.uflow)
      else $error("Underflow pulse without underflow");
   AST_NO_TICK_HOLD: assert property (q.run[0] && !tick && !startZero && !runWr
      |=> $stable(q.count))
      else $error("Counter moved without a tick");
   AST_DIV_WRAP: assert property (carRise && q.divCnt == SLOW_LAST
      |=> q.divCnt == 6'h0)
      else $error("Carrier divider did not wrap");
   AST_DIV_HOLD: assert property (!carRise
      |=> $stable(q.divCnt))
      else $error("Carrier divider moved without an edge");
   AST_ONE_RISE: assert property (carRise
      |=> !carRise)
      else $error("One carrier edge counted twice");

   // Interrupt flags
   AST_STATUS_CLEAR: assert property (busWr && idx == IDX_IRQ_STATUS && wbReq.dat[0]
      && !(q.run[0] && tick && q.count == 16'h0000 && q.startMode != START_LFO_HOLD) |=> !q.status[IRQ_UNDERFLOW_BIT])
      else $error("Write one did not clear underflow flag");
   AST_STATUS_STICKY: assert property (q.status[IRQ_UNDERFLOW_BIT] && !(busWr && idx == IDX_IRQ_STATUS && wbReq.dat[0])
      |=> q.status[IRQ_UNDERFLOW_BIT])
      else $error("Underflow flag cleared by itself");
   AST_IRQ_MASKED: assert property (q.mask == 2'h0
      |-> !irq)
      else $error("Interrupt raised while fully masked");

   COV_RESTART: cover property (q.uflow && q.run[0]);
   COV_HALT_RX: cover property (q.run[0] ##1 q.status[IRQ_HALT_RX_BIT] && !q.run[0]);
   COV_LFO_CYCLE: cover property (lfoMode && lfoRise && !q.run[0] ##[1:1000] lfoRise && q.run[0]);
   COV_IRQ: cover property (irq);
   COV_SLOW_TICK: cover property (slowTick && q.run[0]);

endmodule
`default_nettype wire

/* File: shared/rts_pkg.sv */
package rts_pkg;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_RUN_CONTROL = 6'h0e;
   localparam logic [5:0] IDX_ZERO_CONTROL = 6'h0f;
   localparam logic [5:0] IDX_RELOAD_HIGH = 6'h10;
   localparam logic [5:0] IDX_RELOAD_LOW = 6'h11;
   localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
   localparam logic [5:0] IDX_IRQ_MASK = 6'h21;

   // Field positions
   localparam int RUN_LO = 4;
   localparam int CTL_HALT_BIT = 7;
   localparam int CTL_MODE_LO = 4;
   localparam int CTL_RELOAD_BIT = 3;
   localparam int CTL_CLK_LO = 0;
   localparam int IRQ_UNDERFLOW_BIT = 0;
   localparam int IRQ_HALT_RX_BIT = 1;

   // Timing
   localparam int MCLK_HZ = 25_000_000;
   localparam int CARRIER_HZ = 13_560_000;
   localparam int SLOW_HZ = 211_875;
   localparam int SLOW_DIV = CARRIER_HZ / SLOW_HZ;
   localparam logic [5:0] SLOW_LAST = 6'(SLOW_DIV - 1);

   typedef enum logic [1:0] {START_NONE, START_TX_END, START_LFO_HOLD, START_LFO_WRAP} rts_start_t;
   typedef enum logic [1:0] {CLK_CARRIER, CLK_SLOW, CLK_TIMER_TWO, CLK_TIMER_ONE} rts_clksel_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } rts_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } rts_wb_rsp_t;

   typedef struct packed {
      logic [3:0] run;
      logic haltRx;
      rts_start_t startMode;
      logic autoReload;
      rts_clksel_t clkSel;
      logic [7:0] reloadHi;
      logic [7:0] reloadLo;
      logic [15:0] count;
      logic [5:0] divCnt;
      logic [2:0] carSync;
      logic [2:0] lfoSync;
      logic carLvl;
      logic lfoLvl;
      logic [1:0] status;
      logic [1:0] mask;
      logic ack;
      logic [31:0] rdData;
      logic uflow;
   } rts_state_t;

   localparam rts_state_t RTS_STATE_RESET = '0;

endpackage

/* File: tb/tb_rts_timer_section.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_rts_timer_section import rts_pkg::*;;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic txDone = 1'b0;
   logic rxSeen = 1'b0;
   logic carrierPin = 1'b0;
   logic lfoPin = 1'b0;
   logic oneUf = 1'b0;
   logic twoUf = 1'b0;
   rts_wb_req_t wbReq = '0;
   rts_wb_rsp_t wbRsp;
   logic [3:1] sibRun;
   logic zeroUf;
   logic [15:0] cnt;
   logic irq;
   logic [31:0] rd;
   logic [3:0] runM;
   logic [7:0] w;
   int errors = 0;
   int n_checks = 0;
   int cycles = 0;
   int nUf = 0;

   rts_timer_section uut (.mclk(mclk), .rst_n(rst_n), .wbReq(wbReq), .wbRsp(wbRsp), .txFrameDone(txDone),
      .rxFourBitsSeen(rxSeen), .carrierPin(carrierPin), .lfoPin(lfoPin), .timerOneUnderflow(oneUf),
      .timerTwoUnderflow(twoUf), .siblingRun(sibRun), .timerZeroUnderflow(zeroUf), .counterValue(cnt),
      .irq(irq));

   always #20 mclk = ~mclk;

   // Budget covers all scenarios several times over
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         complete_run;
      end
   end

   // Pulses are counted where they are settled, away from the launching edge
   always @(negedge mclk) begin
      if (zeroUf === 1'b1) nUf++;
   end

   task complete_run;
      $display("errors %0d checks %0d", errors, n_checks);
      if (errors == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, g, e);
      end
   endtask

   function automatic logic [3:0] run_next(input logic [3:0] r, input logic [7:0] v);
      return (r & ~v[3:0]) | (v[7:4] & v[3:0]);
   endfunction

   // Entered just after an edge; request held until ack is sampled
   task wb(input logic [5:0] i, input logic we, input logic [7:0] d);
      int n;
      n = 0;
      wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {i, 2'b00}, sel: 4'hf, dat: {24'h00_0000, d}};
      do begin
         @(negedge mclk);
         n++;
      end while (wbRsp.ack !== 1'b1 && n < 20);
      rd = wbRsp.dat;
      chk(32'(wbRsp.ack), 32'h0000_0001);
      @(posedge mclk);
      wbReq <= '0;
      @(posedge mclk);
   endtask

   task waitc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task chk_run(input logic e);
      wb(IDX_RUN_CONTROL, 1'b0, 8'h00);
      chk(32'(rd[4]), 32'(e));
   endtask

   // Sibling underflow pulse, then time for count, flag and reload to settle
   task tick(input logic one);
      oneUf <= one;
      twoUf <= !one;
      @(posedge mclk);
      oneUf <= 1'b0;
      twoUf <= 1'b0;
      waitc(3);
   endtask

   task pulse(input logic rx);
      txDone <= !rx;
      rxSeen <= rx;
      @(posedge mclk);
      txDone <= 1'b0;
      rxSeen <= 1'b0;
      waitc(3);
   endtask

   initial begin
      void'($urandom(2389));
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      wb(IDX_ZERO_CONTROL, 1'b0, 8'h00);
      chk(rd, 32'h0000_0000);
      runM = 4'h0;
      for (int k = 0; k < 24; k++) begin
         w = 8'($urandom);
         if (k == 0) w = 8'hff;
         if (k == 1) w = 8'hf0;
         wb(IDX_RUN_CONTROL, 1'b1, w);
         runM = run_next(runM, w);
         wb(IDX_RUN_CONTROL, 1'b0, 8'h00);
         chk(rd, {24'h00_0000, runM, 4'h0});
         chk(32'(sibRun), 32'(runM[3:1]));
      end
      wb(IDX_RUN_CONTROL, 1'b1, 8'h0f);
      for (int k = 0; k < 8; k++) begin
         w = 8'($urandom);
         wb(IDX_ZERO_CONTROL, 1'b1, w);
         wb(IDX_ZERO_CONTROL, 1'b0, 8'h00);
         chk(rd, {24'h00_0000, w & 8'hbb});
         wb(IDX_RELOAD_HIGH, 1'b1, w);
         wb(IDX_RELOAD_LOW, 1'b1, ~w);
         wb(IDX_RELOAD_HIGH, 1'b0, 8'h00);
         chk(rd, {24'h00_0000, w});
         wb(IDX_RELOAD_LOW, 1'b0, 8'h00);
         chk(rd, {24'h00_0000, ~w});
      end
      // Ticks from timer two, single shot
      wb(IDX_IRQ_MASK, 1'b1, 8'h03);
      wb(IDX_ZERO_CONTROL, 1'b1, 8'h02);
      wb(IDX_RELOAD_HIGH, 1'b1, 8'h00);
      wb(IDX_RELOAD_LOW, 1'b1, 8'h03);
      wb(IDX_RUN_CONTROL, 1'b1, 8'h11);
      chk(32'(cnt), 32'h0000_0003);
      wb(IDX_RELOAD_LOW, 1'b1, 8'h02);
      chk(32'(cnt), 32'h0000_0003);
      tick(1'b1);
      chk(32'(cnt), 32'h0000_0003);
      nUf = 0;
      for (int k = 2; k >= 0; k--) begin
         tick(1'b0);
         chk(32'(cnt), 32'(k));
      end
      tick(1'b0);
      chk(32'(nUf), 32'h0000_0001);
      chk_run(1'b0);
      chk(32'(irq), 32'h0000_0001);
      wb(IDX_IRQ_STATUS, 1'b1, 8'h01);
      chk(32'(irq), 32'h0000_0000);
      tick(1'b0);
      chk(32'(cnt), 32'h0000_0000);
      // Ticks from timer one, auto restart
      wb(IDX_ZERO_CONTROL, 1'b1, 8'h0b);
      wb(IDX_RUN_CONTROL, 1'b1, 8'h11);
      tick(1'b1);
      tick(1'b1);
      tick(1'b1);
      chk(32'(cnt), 32'h0000_0002);
      chk(32'(nUf), 32'h0000_0002);
      chk_run(1'b1);
      // End of transmission start, then halt on receive
      wb(IDX_IRQ_STATUS, 1'b1, 8'h03);
      wb(IDX_RUN_CONTROL, 1'b1, 8'h01);
      wb(IDX_ZERO_CONTROL, 1'b1, 8'h90);
      pulse(1'b0);
      chk(32'(cnt), 32'h0000_0002);
      chk_run(1'b1);
      pulse(1'b1);
      chk_run(1'b0);
      chk(32'(irq), 32'h0000_0001);
      wb(IDX_IRQ_MASK, 1'b1, 8'h00);
      chk(32'(irq), 32'h0000_0000);
      // Trimming mode toggles on oscillator rising edges; halt ignored
      wb(IDX_ZERO_CONTROL, 1'b1, 8'ha0);
      lfoPin <= 1'b1;
      waitc(6);
      chk_run(1'b1);
      pulse(1'b1);
      chk_run(1'b1);
      lfoPin <= 1'b0;
      waitc(6);
      lfoPin <= 1'b1;
      waitc(6);
      chk_run(1'b0);
      // Carrier ticks; slow toggling so no edge merges at the sampler
      wb(IDX_ZERO_CONTROL, 1'b1, 8'h00);
      pulse(1'b0);
      chk_run(1'b0);
      wb(IDX_RELOAD_LOW, 1'b1, 8'h05);
      wb(IDX_RUN_CONTROL, 1'b1, 8'h11);
      repeat (3) begin
         carrierPin <= 1'b1;
         waitc(4);
         carrierPin <= 1'b0;
         waitc(4);
      end
      waitc(4);
      chk(32'(cnt), 32'h0000_0002);
      // Slow clock: exactly one tick in any 64 carrier edges, whatever the divider phase
      wb(IDX_ZERO_CONTROL, 1'b1, 8'h01);
      wb(IDX_RELOAD_LOW, 1'b1, 8'h01);
      wb(IDX_RUN_CONTROL, 1'b1, 8'h11);
      repeat (64) begin
         carrierPin <= 1'b1;
         waitc(4);
         carrierPin <= 1'b0;
         waitc(4);
      end
      waitc(4);
      chk(32'(cnt), 32'h0000_0000);
      chk_run(1'b1);
      complete_run;
   end
endmodule
`default_nettype wire
